/* File: rtl/acsr_pkg.sv */
/*
 * Constants and types shared by the actuator control/status register bank:
 * frame layout of the second control word and the second fault report,
 * timing figures and the over-current retry state encoding.
 * Assumes a 20 MHz system clock and a 24-bit serial frame, MSB first.
 */
// What this block does
// - Control bit 23 selects active or standby
// - Entering standby clears every held bit
// - After power-on reset start in standby
// - Status bit 23 always reads one
// - Over-current sets flag, switches output off
// - Retry enable reactivates output after delay, repeatedly
// - Over/undervoltage set bits 22/21, outputs off
// - Supply recovery reactivates outputs automatically
// - Thermal shutdown sets bit 20, outputs off
// - Shutdown flag held until reset bit written
// - Temperature warning held until software clears
// - Start settling timer, no output until expiry
// - Bit 18 set only while timer runs
// - Not-ready duration counted on internal clock
// - Bit 0 is NOR of bits 1-22 and the first register's fault summary

package acsr_pkg;

	// Frame
	localparam int FRAME_BITS        = 24;
	localparam int BIT_CNT_W         = 5;

	// Control word field positions
	localparam int CW_ENABLE_BIT     = 23;
	localparam int CW_RETRY8_BIT     = 22;
	localparam int CW_RETRY7_BIT     = 20;
	localparam int CW_RETRY6_BIT     = 19;

	// Fault report field positions
	localparam int FR_ALWAYS_ONE_BIT = 23;
	localparam int FR_OV_BIT         = 22;
	localparam int FR_UV_BIT         = 21;
	localparam int FR_TSD_BIT        = 20;
	localparam int FR_TW_BIT         = 19;
	localparam int FR_NOT_READY_BIT  = 18;
	localparam int FR_LOWER_MSB      = 17;
	localparam int FR_LOWER_W        = 17;
	localparam int FR_NO_ERROR_BIT   = 0;

	// Timing figures
	localparam int CLK_PERIOD_NS     = 50;
	localparam int SETTLE_TIME_NS    = 100000;
	localparam int RETRY_SHORT_NS    = 100000;
	localparam int RETRY_LONG_NS     = 200000;
	localparam int CNT_W             = 16;

	// Least times round up to whole cycles
	localparam int SETTLE_CYCLES      = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRY_SHORT_CYCLES = (RETRY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRY_LONG_CYCLES  = (RETRY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Over-current retry states
	typedef enum logic [1:0] {
		RT_ON      = 2'b00,
		RT_TRIPPED = 2'b01,
		RT_WAIT    = 2'b10
	} acsr_retry_state_t;

endpackage : acsr_pkg

/* File: rtl/acsr_sync.sv */
/*
 * Two-flop synchroniser for a group of independent levels.
 * Assumes each bit is a level that may change at any time; no bus coherence.
 */
`timescale 1ns/10ps
`default_nettype none

module acsr_sync
	import acsr_pkg::*;
#(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q, meta_d;
	logic [W-1:0] stab_q, stab_d;

	// First stage is read only by the second
	always_comb begin
		meta_d = async_in;
		stab_d = meta_q;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			meta_q <= RST_VAL;
			stab_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			stab_q <= stab_d;
		end
	end

	assign sync_out = stab_q;

endmodule : acsr_sync

`default_nettype wire

/* File: rtl/acsr_oc_retry.sv */
/*
 * Over-current latch and automatic retry for one high-side output.
 * Assumes oc_level is already synchronised and that the caller gates the
 * final output with mode, supply and thermal state.
 */
`timescale 1ns/10ps
`default_nettype none

module acsr_oc_retry
	import acsr_pkg::*;
#(
	parameter int SHORT_CYCLES = RETRY_SHORT_CYCLES,
	parameter int LONG_CYCLES  = RETRY_LONG_CYCLES
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// Control
	input  wire logic standby,
	input  wire logic clear_req,
	input  wire logic retry_en,
	input  wire logic duty_long,
	// Fault in, state out
	input  wire logic oc_level,
	output logic      oc_flag,
	output logic      conduct
);

	acsr_retry_state_t state_q, state_d;
	logic [CNT_W-1:0]  cnt_q, cnt_d;
	logic              flag_q, flag_d;
	logic              trip;

	// Trip only counts while the output is allowed to conduct
	assign trip = (state_q == RT_ON) && oc_level;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		// Set wins over clear so a trip in the clearing cycle survives
		flag_d  = (flag_q && !clear_req && !standby) || trip;
		unique case (state_q)
			RT_ON: begin
				if (trip) begin
					state_d = retry_en ? RT_WAIT : RT_TRIPPED;
					cnt_d   = duty_long ? CNT_W'(LONG_CYCLES) : CNT_W'(SHORT_CYCLES);
				end
			end
			RT_TRIPPED: begin
				if (clear_req) begin
					state_d = RT_ON;
				end else if (retry_en) begin
					state_d = RT_WAIT; // Late enable still gets a retry
				end
			end
			RT_WAIT: begin
				if (cnt_q == '0) begin
					state_d = RT_ON;
				end else begin
					cnt_d = cnt_q - CNT_W'(1);
				end
			end
			default: state_d = RT_ON;
		endcase
		if (standby) begin
			state_d = RT_ON;
			cnt_d   = '0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= RT_ON;
			cnt_q   <= '0;
			flag_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			flag_q  <= flag_d;
		end
	end

	assign oc_flag = flag_q;
	assign conduct = (state_q == RT_ON);

endmodule : acsr_oc_retry

`default_nettype wire

/* File: rtl/acsr_top.sv */
/*
 * Second control word and second fault report of the actuator driver,
 * reached over the serial link: mode select, over-current retry enables
 * for the three high-side outputs, supply, thermal and start-up status.
 * Assumes the link pins are asynchronous to clock (sampled through two
 * flops), and that the first register pair lives outside and supplies the
 * reset bit, duty selection, output requests and its own fault summary.
 */
`timescale 1ns/10ps
`default_nettype none

module acsr_top
	import acsr_pkg::*;
#(
	parameter int SETTLE_CNT      = SETTLE_CYCLES,
	parameter int RETRY_SHORT_CNT = RETRY_SHORT_CYCLES,
	parameter int RETRY_LONG_CNT  = RETRY_LONG_CYCLES
) (
	// Clock and reset
	input  wire logic                  clock,
	input  wire logic                  rst,
	// Serial link pins
	input  wire logic                  spi_csn_n,
	input  wire logic                  spi_sclk,
	input  wire logic                  spi_sdi,
	output logic                       spi_sdo,
	output logic                       spi_sdo_oe_n,
	// Analogue fault detectors (asynchronous levels)
	input  wire logic                  load_supply_voltage_over,
	input  wire logic                  load_supply_voltage_under,
	input  wire logic                  thermal_shutdown_event,
	input  wire logic                  temperature_warning_event,
	input  wire logic [2:0]            overcurrent_event,
	// First register pair (same clock)
	input  wire logic                  status_reset_req,
	input  wire logic                  retry_duty_long,
	input  wire logic [2:0]            output_on_req,
	input  wire logic                  reg0_fault_any,
	input  wire logic [FR_LOWER_W-1:0] lower_status,
	// Power stage controls, flags and frame strobe
	output logic                       active_mode,
	output logic [2:0]                 hs_output_enable,
	output logic [2:0]                 overcurrent_flag,
	output logic                       frame_done
);

	// Edge helpers on synchronised levels
	function automatic logic rose(input logic now, input logic prev);
		rose = now && !prev;
	endfunction : rose

	function automatic logic fell(input logic now, input logic prev);
		fell = !now && prev;
	endfunction : fell

	// Synchronised pins
	logic       csn_s;
	logic       sclk_s;
	logic       sdi_s;
	logic [3:0] supply_thermal_s;
	logic [2:0] oc_s;
	logic       ov_s;
	logic       uv_s;
	logic       tsd_s;
	logic       tw_s;

	acsr_sync #(
		.W       (3),
		.RST_VAL (3'h4)
	) u_sync_link (
		.clock    (clock),
		.rst      (rst),
		.async_in ({spi_csn_n, spi_sclk, spi_sdi}),
		.sync_out ({csn_s, sclk_s, sdi_s})
	);

	acsr_sync #(
		.W       (7),
		.RST_VAL (7'h00)
	) u_sync_faults (
		.clock    (clock),
		.rst      (rst),
		.async_in ({load_supply_voltage_over, load_supply_voltage_under,
		            thermal_shutdown_event, temperature_warning_event, overcurrent_event}),
		.sync_out ({supply_thermal_s, oc_s})
	);

	assign ov_s  = supply_thermal_s[3];
	assign uv_s  = supply_thermal_s[2];
	assign tsd_s = supply_thermal_s[1];
	assign tw_s  = supply_thermal_s[0];

	// Serial engine state
	logic                  csn_prev_q, csn_prev_d;
	logic                  sclk_prev_q, sclk_prev_d;
	logic [FRAME_BITS-1:0] in_sh_q, in_sh_d;
	logic [FRAME_BITS-1:0] out_sh_q, out_sh_d;
	logic [BIT_CNT_W-1:0]  bit_cnt_q, bit_cnt_d;
	logic                  sdo_q, sdo_d;
	logic                  sdo_oe_n_q, sdo_oe_n_d;
	logic                  commit;
	logic                  frame_done_q, frame_done_d;

	// Register and status state
	logic             enable_q, enable_d;
	logic [2:0]       retry_en_q, retry_en_d;
	logic             ov_q, ov_d;
	logic             uv_q, uv_d;
	logic             tsd_q, tsd_d;
	logic             tw_q, tw_d;
	logic             not_ready_q, not_ready_d;
	logic [CNT_W-1:0] settle_q, settle_d;
	logic [2:0]       hs_en_q, hs_en_d;
	logic             standby;
	logic             going_active;
	logic [2:0]       conduct;
	logic [2:0]       oc_flag;
	logic [FRAME_BITS-1:0] report;

	// Only a frame of exactly 24 clocks is taken; others are ignored
	assign commit       = rose(csn_s, csn_prev_q) && (bit_cnt_q == BIT_CNT_W'(FRAME_BITS));
	assign standby      = !enable_q;
	assign going_active = commit && in_sh_q[CW_ENABLE_BIT] && !enable_q;

	// Fault report assembled from the held flags
	always_comb begin
		report                    = '0;
		report[FR_ALWAYS_ONE_BIT] = 1'b1;
		report[FR_OV_BIT]         = ov_q;
		report[FR_UV_BIT]         = uv_q;
		report[FR_TSD_BIT]        = tsd_q;
		report[FR_TW_BIT]         = tw_q;
		report[FR_NOT_READY_BIT]  = not_ready_q;
		report[FR_LOWER_MSB:1]    = lower_status;
		report[FR_NO_ERROR_BIT]   = !(|report[FR_OV_BIT:1]) && !reg0_fault_any;
	end

	// Serial shifting: sample on rising sclk, shift out on falling sclk
	always_comb begin
		csn_prev_d   = csn_s;
		sclk_prev_d  = sclk_s;
		in_sh_d      = in_sh_q;
		out_sh_d     = out_sh_q;
		bit_cnt_d    = bit_cnt_q;
		sdo_d        = sdo_q;
		sdo_oe_n_d   = csn_s;
		frame_done_d = commit;
		if (fell(csn_s, csn_prev_q)) begin
			// Snapshot taken at select so the frame is self-consistent
			out_sh_d  = report;
			sdo_d     = report[FRAME_BITS-1];
			bit_cnt_d = '0;
		end else if (!csn_s) begin
			if (rose(sclk_s, sclk_prev_q)) begin
				in_sh_d = {in_sh_q[FRAME_BITS-2:0], sdi_s};
				if (bit_cnt_q != BIT_CNT_W'(FRAME_BITS + 1)) begin
					bit_cnt_d = bit_cnt_q + BIT_CNT_W'(1);
				end
			end else if (fell(sclk_s, sclk_prev_q)) begin
				out_sh_d = {out_sh_q[FRAME_BITS-2:0], 1'b0};
				sdo_d    = out_sh_q[FRAME_BITS-2];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			csn_prev_q   <= 1'b1;
			sclk_prev_q  <= 1'b0;
			in_sh_q      <= '0;
			out_sh_q     <= '0;
			bit_cnt_q    <= '0;
			sdo_q        <= 1'b0;
			sdo_oe_n_q   <= 1'b1;
			frame_done_q <= 1'b0;
		end else begin
			csn_prev_q   <= csn_prev_d;
			sclk_prev_q  <= sclk_prev_d;
			in_sh_q      <= in_sh_d;
			out_sh_q     <= out_sh_d;
			bit_cnt_q    <= bit_cnt_d;
			sdo_q        <= sdo_d;
			sdo_oe_n_q   <= sdo_oe_n_d;
			frame_done_q <= frame_done_d;
		end
	end

	// Control word: mode and retry enables
	always_comb begin
		enable_d   = enable_q;
		retry_en_d = retry_en_q;
		if (commit) begin
			enable_d   = in_sh_q[CW_ENABLE_BIT];
			retry_en_d = {in_sh_q[CW_RETRY8_BIT], in_sh_q[CW_RETRY7_BIT],
			              in_sh_q[CW_RETRY6_BIT]};
			if (!in_sh_q[CW_ENABLE_BIT]) begin
				retry_en_d = '0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			enable_q   <= 1'b0;
			retry_en_q <= '0;
		end else begin
			enable_q   <= enable_d;
			retry_en_q <= retry_en_d;
		end
	end

	// Sticky fault flags; a set in the clearing cycle wins
	always_comb begin
		ov_d  = (ov_q && !status_reset_req) || ov_s;
		uv_d  = (uv_q && !status_reset_req) || uv_s;
		tsd_d = (tsd_q && !status_reset_req) || tsd_s;
		tw_d  = (tw_q && !status_reset_req) || tw_s;
		if (standby) begin
			// Standby holds every bit clear, detectors are powered down
			ov_d  = 1'b0;
			uv_d  = 1'b0;
			tsd_d = 1'b0;
			tw_d  = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ov_q  <= 1'b0;
			uv_q  <= 1'b0;
			tsd_q <= 1'b0;
			tw_q  <= 1'b0;
		end else begin
			ov_q  <= ov_d;
			uv_q  <= uv_d;
			tsd_q <= tsd_d;
			tw_q  <= tw_d;
		end
	end

	// Start-up settling timer, counted on clock so its length is exact
	always_comb begin
		settle_d    = settle_q;
		not_ready_d = not_ready_q;
		if (going_active) begin
			settle_d    = CNT_W'(SETTLE_CNT - 1);
			not_ready_d = 1'b1;
		end else if (standby) begin
			settle_d    = '0;
			not_ready_d = 1'b0;
		end else if (not_ready_q) begin
			if (settle_q == '0) begin
				not_ready_d = 1'b0;
			end else begin
				settle_d = settle_q - CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			settle_q    <= '0;
			not_ready_q <= 1'b0;
		end else begin
			settle_q    <= settle_d;
			not_ready_q <= not_ready_d;
		end
	end

	// One retry engine per high-side output (index 2 = output eight)
	for (genvar i = 0; i < 3; i++) begin : g_retry
		acsr_oc_retry #(
			.SHORT_CYCLES (RETRY_SHORT_CNT),
			.LONG_CYCLES  (RETRY_LONG_CNT)
		) u_retry (
			.clock     (clock),
			.rst       (rst),
			.standby   (standby),
			.clear_req (status_reset_req),
			.retry_en  (retry_en_q[i]),
			.duty_long (retry_duty_long),
			.oc_level  (oc_s[i] && hs_en_q[i]),
			.oc_flag   (oc_flag[i]),
			.conduct   (conduct[i])
		);
	end

	// Output permit: supply state is live so recovery needs no software
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			hs_en_d[i] = enable_q && !not_ready_q
			             && !tsd_q
			             && !ov_s && !uv_s
			             && conduct[i]
			             && output_on_req[i];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			hs_en_q <= '0;
		end else begin
			hs_en_q <= hs_en_d;
		end
	end

	assign spi_sdo          = sdo_q;
	assign spi_sdo_oe_n     = sdo_oe_n_q;
	assign active_mode      = enable_q;
	assign hs_output_enable = hs_en_q;
	assign overcurrent_flag = oc_flag;
	assign frame_done       = frame_done_q;

endmodule : acsr_top

`default_nettype wire

/* File: tb/acsr_checker.sv */
/*
 * Port-level checker for the actuator control/status register bank.
 * Assumes it is bound into acsr_top and handed the same timing counts.
 */
`timescale 1ns/10ps
`default_nettype none

module acsr_checker
	import acsr_pkg::*;
#(
	parameter int SETTLE_CNT      = SETTLE_CYCLES,
	parameter int RETRY_SHORT_CNT = RETRY_SHORT_CYCLES,
	parameter int RETRY_LONG_CNT  = RETRY_LONG_CYCLES
) (
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst,
	// Link and fault inputs
	input wire logic       spi_csn_n,
	input wire logic       spi_sdo,
	input wire logic       spi_sdo_oe_n,
	input wire logic       load_supply_voltage_over,
	input wire logic       load_supply_voltage_under,
	input wire logic       thermal_shutdown_event,
	input wire logic [2:0] overcurrent_event,
	input wire logic       status_reset_req,
	// Outputs watched
	input wire logic       active_mode,
	input wire logic [2:0] hs_output_enable,
	input wire logic [2:0] overcurrent_flag,
	input wire logic       frame_done
);
	logic [15:0] settle_q;
	logic [15:0] settle_d;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Cycles spent in active mode, saturating so it never wraps back into the gate
	always_comb begin
		settle_d = settle_q;
		if (!active_mode) settle_d = 16'h0000;
		else if (settle_q != 16'hffff) settle_d = settle_q + 16'h0001;
	end

	always_ff @(posedge clock) begin
		settle_q <= rst ? 16'h0000 : settle_d;
	end

	a_settle_gate: assert property (active_mode && settle_q < SETTLE_CNT |-> hs_output_enable == 3'h0)
		else $error("output on during settling");
	a_standby_off: assert property (!active_mode && !$past(active_mode) |-> hs_output_enable == 3'h0)
		else $error("output on in standby");
	a_mode_frame: assert property ($changed(active_mode) |-> frame_done)
		else $error("mode changed without a frame");
	a_done_pulse: assert property (frame_done |=> !frame_done)
		else $error("frame pulse longer than one cycle");
	a_first_one: assert property ($fell(spi_sdo_oe_n) |-> spi_sdo)
		else $error("first report bit not one");
	a_oe_idle: assert property (spi_csn_n [*6] |-> spi_sdo_oe_n)
		else $error("data out driven while deselected");
	a_supply_gate: assert property (
		(load_supply_voltage_over || load_supply_voltage_under) [*5] |-> hs_output_enable == 3'h0)
		else $error("output on during supply fault");
	a_tsd_gate: assert property (thermal_shutdown_event [*5] |-> hs_output_enable == 3'h0)
		else $error("output on during thermal shutdown");
	a_flag_sticky: assert property (overcurrent_flag[2] && !status_reset_req
		&& !$past(status_reset_req) |=> overcurrent_flag[2] || !active_mode)
		else $error("over-current flag dropped without reset bit");

	// Trip latches the flag and cuts the output well inside any retry delay
	for (genvar g = 0; g < 3; g++) begin : g_oc
		a_oc_trip: assert property ((hs_output_enable[g] && overcurrent_event[g]) ##1
			overcurrent_event[g] [*5] |-> overcurrent_flag[g] && !hs_output_enable[g])
			else $error("trip did not latch or switch off");
	end

	c_enable: cover property ($rose(active_mode));
	c_trip: cover property ($rose(overcurrent_flag[2]));
	c_frame: cover property ($fell(spi_sdo_oe_n));
endmodule : acsr_checker

bind acsr_top acsr_checker #(
	.SETTLE_CNT(SETTLE_CNT),
	.RETRY_SHORT_CNT(RETRY_SHORT_CNT),
	.RETRY_LONG_CNT(RETRY_LONG_CNT)
) u_acsr_checker (.clock, .rst, .spi_csn_n, .spi_sdo, .spi_sdo_oe_n,
	.load_supply_voltage_over, .load_supply_voltage_under, .thermal_shutdown_event,
	.overcurrent_event, .status_reset_req, .active_mode, .hs_output_enable,
	.overcurrent_flag, .frame_done);

`default_nettype wire

/* File: tb/acsr_spi_master.sv */
/*
 * Serial-link master standing in for the microcontroller.
 * Assumes the device samples on serial clock rise; the clock idles low.
 */
`timescale 1ns/10ps
`default_nettype none

module acsr_spi_master (
	// Clock
	input  wire logic clock,
	// Link pins
	output logic      spi_csn_n,
	output logic      spi_sclk,
	output logic      spi_sdi,
	input  wire logic spi_sdo
);
	initial begin
		spi_csn_n = 1'b1;
		spi_sclk  = 1'b0;
		spi_sdi   = 1'b1;
	end

	// One frame of n bits, MSB first, 400 ns serial period
	task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
		r = 24'h000000;
		@(posedge clock);
		spi_csn_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_sdi <= (i < 24) ? w[23 - i] : 1'b0;
			repeat (4) @(posedge clock);
			spi_sclk <= 1'b1;
			repeat (4) @(posedge clock);
			r = {r[22:0], spi_sdo}; // Sampled late in the bit, where it has settled
			spi_sclk <= 1'b0;
		end
		repeat (4) @(posedge clock);
		spi_csn_n <= 1'b1;
		spi_sdi   <= ~spi_sdi; // A released line must not look held
		repeat (8) @(posedge clock);
	endtask : xfer
endmodule : acsr_spi_master

`default_nettype wire

/* File: tb/acsr_top_tb.sv */
/*
 * Self-checking bench for acsr_top with the serial master model.
 * Assumes shortened settle and retry counts set below.
 */
`timescale 1ns/10ps
`default_nettype none

module acsr_top_tb
	import acsr_pkg::*;
;
	localparam int ST = 400;
	localparam int RS = 10;
	localparam int RL = 20;

	// Design connections
	logic        clock = 1'b0, rst = 1'b1, spi_csn_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe_n;
	logic        load_supply_voltage_over = 1'b0, load_supply_voltage_under = 1'b0;
	logic        thermal_shutdown_event = 1'b0, temperature_warning_event = 1'b0;
	logic [2:0]  overcurrent_event = 3'h0, output_on_req = 3'h7;
	logic        status_reset_req = 1'b0, retry_duty_long = 1'b0, reg0_fault_any = 1'b0;
	logic [16:0] lower_status = 17'h00000;
	logic        active_mode, frame_done, act_d = 1'b0;
	logic [2:0]  hs_output_enable, overcurrent_flag;
	// Bench bookkeeping
	logic [23:0] r;
	int          n_fail = 0, compares = 0, n_done = 0, cyc_n = 0, t_en = 0;

	acsr_top #(.SETTLE_CNT(ST), .RETRY_SHORT_CNT(RS), .RETRY_LONG_CNT(RL)) u_acsr_top (.*);
	// Released data line shows the inverse of the last bit, so a read outside the frame fails
	acsr_spi_master u_acsr_spi_master (.clock, .spi_csn_n, .spi_sclk, .spi_sdi,
		.spi_sdo(spi_sdo_oe_n ? ~spi_sdo : spi_sdo));

	always #25 clock = ~clock;

	// Frame count and the cycle stamp of each entry into active mode
	always @(posedge clock) begin
		cyc_n <= cyc_n + 1;
		act_d <= active_mode;
		if (frame_done === 1'b1) n_done <= n_done + 1;
		if (active_mode === 1'b1 && act_d === 1'b0) t_en <= cyc_n;
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	task automatic fr(input logic [23:0] w, input int n = 24);
		u_acsr_spi_master.xfer(w, n, r);
	endtask : fr

	// Bounded wait for one output to reach a level
	task automatic wait_hs(input int i, input logic v, input int lim, output int n);
		n = 0;
		while (hs_output_enable[i] !== v && n < lim) begin
			@(posedge clock);
			n++;
		end
	endtask : wait_hs

	// Reset bit of the first control register, one cycle wide
	task automatic clr;
		status_reset_req <= 1'b1;
		cyc(1);
		status_reset_req <= 1'b0;
		cyc(3);
	endtask : clr

	task automatic t_enable;
		int n;
		chk({active_mode, hs_output_enable, spi_sdo_oe_n}, 24'h1);
		fr(24'h000000);
		chk(r, 24'h800001);
		fr(24'h800000);
		chk(active_mode, 1'b1);
		fr(24'h800000);
		chk(r, 24'h840000);
		chk(hs_output_enable, 3'h0);
		wait_hs(0, 1'b1, ST, n);
		chk(cyc_n - t_en >= ST && cyc_n - t_en <= ST + 4, 1'b1);
		fr(24'h800000);
		chk(r, 24'h800001);
	endtask : t_enable

	// Each output trips with its own retry bit; output eight uses the long off time
	task automatic t_oc;
		int pos[3] = '{19, 20, 22};
		int n;
		for (int k = 0; k < 3; k++) begin
			retry_duty_long <= (k == 2);
			fr(24'h800000 | (24'h1 << pos[k]));
			overcurrent_event <= 3'h1 << k;
			cyc(8);
			chk(overcurrent_flag, 3'h1 << k);
			overcurrent_event <= 3'h0;
			wait_hs(k, 1'b1, RL + 12, n);
			chk((n > RS) == (k == 2) && hs_output_enable[k] === 1'b1, 1'b1);
			clr();
			chk(overcurrent_flag, 3'h0);
		end
		fr(24'h800000);
		overcurrent_event <= 3'h2;
		cyc(8);
		overcurrent_event <= 3'h0;
		cyc(3 * RL);
		chk(overcurrent_flag, 3'h2);
		clr();
		wait_hs(1, 1'b1, 20, n);
		chk(hs_output_enable, 3'h7);
	endtask : t_oc

	task automatic t_supply;
		int n;
		for (int k = 0; k < 2; k++) begin
			load_supply_voltage_over  <= (k == 0);
			load_supply_voltage_under <= (k == 1);
			cyc(8);
			chk(hs_output_enable, 3'h0);
			fr(24'h800000);
			chk(r, (k == 0) ? 24'hc00000 : 24'ha00000);
			load_supply_voltage_over  <= 1'b0;
			load_supply_voltage_under <= 1'b0;
			wait_hs(0, 1'b1, 20, n);
			chk(hs_output_enable, 3'h7);
			clr();
		end
	endtask : t_supply

	task automatic t_thermal;
		int n;
		thermal_shutdown_event <= 1'b1;
		cyc(8);
		chk(hs_output_enable, 3'h0);
		thermal_shutdown_event <= 1'b0;
		fr(24'h800000);
		chk(r, 24'h900000);
		chk(hs_output_enable, 3'h0);
		clr();
		wait_hs(0, 1'b1, 20, n);
		chk(hs_output_enable, 3'h7);
		temperature_warning_event <= 1'b1;
		cyc(8);
		temperature_warning_event <= 1'b0;
		fr(24'h800000);
		chk(r, 24'h880000);
		clr();
		fr(24'h800000);
		chk(r, 24'h800001);
	endtask : t_thermal

	// Lower report bits, the summary bit, refused frames and the fall to standby
	task automatic t_misc;
		int d;
		lower_status <= 17'h0a5a5;
		fr(24'h800000);
		chk(r, {6'h20, 17'h0a5a5, 1'b0});
		lower_status   <= 17'h00000;
		reg0_fault_any <= 1'b1;
		fr(24'h800000);
		chk(r, 24'h800000);
		reg0_fault_any <= 1'b0;
		d = n_done;
		fr(24'h000000, 23);
		fr(24'h000000, 25);
		chk({active_mode, n_done == d}, 2'h3);
		temperature_warning_event <= 1'b1;
		cyc(8);
		temperature_warning_event <= 1'b0;
		fr(24'h000000);
		chk({active_mode, hs_output_enable}, 4'h0);
		fr(24'h000000);
		chk(r, 24'h800001);
	endtask : t_misc

	task automatic wrap_up;
		if (n_fail == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up

	initial begin
		cyc(16);
		rst <= 1'b0;
		cyc(3);
		t_enable();
		t_oc();
		t_supply();
		t_thermal();
		t_misc();
		wrap_up();
	end

	// A hang counts as a mismatch and ends the run the usual way
	initial begin
		cyc(40000);
		n_fail++;
		wrap_up();
	end
endmodule : acsr_top_tb

`default_nettype wire
